// ===== rtl/dci_consts.vh
`ifndef DCI_CONSTS_VH
`define DCI_CONSTS_VH

// ****************************************
// Register map
// ****************************************
`define DCI_ADDR_IRQ_CTRL   4'h0
`define DCI_ADDR_IRQ_STATUS 4'h4
`define DCI_ADDR_IRQ_MASK   4'h8

// ****************************************
// Field layout
// ****************************************
`define DCI_EN_LSB          16
`define DCI_EN_MSB          23
`define DCI_FLAG_LSB        0
`define DCI_FLAG_MSB        7
`define DCI_BIT_SRC_DONE    7
`define DCI_BIT_SRC_HALF    6
`define DCI_BIT_DST_DONE    5
`define DCI_BIT_DST_HALF    4
`define DCI_BIT_BLOCK_DONE  3
`define DCI_BIT_CELL_DONE   2
`define DCI_BIT_ABORT       1
`define DCI_BIT_ADDR_ERR    0

// ****************************************
// Reset values
// ****************************************
`define DCI_EN_RESET        8'h00
`define DCI_FLAG_RESET      8'h00
`define DCI_MASK_RESET      8'h00

`endif

// ===== rtl/dci_channel_irq.v
`timescale 1ns/1ps
`default_nettype none
`include "dci_consts.vh"

module dci_channel_irq #(
  parameter PTR_W  = 16,
  parameter ADDR_W = 4
) (
  // Clock and reset
  input  wire              ref_clk,
  input  wire              rst,
  // Register port
  input  wire [ADDR_W-1:0] regAddr,
  input  wire [31:0]       regWrData,
  input  wire              regWrite,
  input  wire              regRead,
  output reg  [31:0]       regRdData,
  // Transfer engine status
  input  wire [PTR_W-1:0]  source_position,
  input  wire [PTR_W-1:0]  source_size,
  input  wire              srcHalfEvt,
  input  wire              dstDoneEvt,
  input  wire              dstHalfEvt,
  input  wire              blockDoneEvt,
  input  wire              cellDoneEvt,
  input  wire              addrErrEvt,
  // Abort trigger
  input  wire [7:0]        irqNumber,
  input  wire              irqValid,
  input  wire [7:0]        abortIrqSel,
  input  wire              abortIrqEn,
  output reg               abortReq,
  // Interrupts
  output wire              chanIrq,
  output wire              irqOut
);

  // ****************************************
  // Event detection
  // ****************************************
  reg  [7:0] irqEn;
  reg  [7:0] flags;
  reg  [7:0] status;
  reg  [7:0] mask;
  reg        srcAtEnd;
  wire       srcMatch;
  wire       abortHit;
  wire [7:0] evt;

  assign srcMatch = (source_position == source_size);
  assign abortHit = irqValid && abortIrqEn && (irqNumber == abortIrqSel);

  // Edge of the match so a held equality does not re-set a cleared flag
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      srcAtEnd <= 1'b0;
    end else begin
      srcAtEnd <= srcMatch;
    end
  end

  // Named events keep the bit order in one place
  wire srcDoneSet;
  wire srcHalfSet;
  wire dstDoneSet;
  wire dstHalfSet;
  wire blockDoneSet;
  wire cellDoneSet;
  wire abortSet;
  wire addrErrSet;

  assign srcDoneSet   = srcMatch && !srcAtEnd;
  assign srcHalfSet   = srcHalfEvt;
  assign dstDoneSet   = dstDoneEvt;
  assign dstHalfSet   = dstHalfEvt;
  assign blockDoneSet = blockDoneEvt;
  assign cellDoneSet  = cellDoneEvt;
  assign abortSet     = abortHit;
  assign addrErrSet   = addrErrEvt;

  assign evt[`DCI_BIT_SRC_DONE]   = srcDoneSet;
  assign evt[`DCI_BIT_SRC_HALF]   = srcHalfSet;
  assign evt[`DCI_BIT_DST_DONE]   = dstDoneSet;
  assign evt[`DCI_BIT_DST_HALF]   = dstHalfSet;
  assign evt[`DCI_BIT_BLOCK_DONE] = blockDoneSet;
  assign evt[`DCI_BIT_CELL_DONE]  = cellDoneSet;
  assign evt[`DCI_BIT_ABORT]      = abortSet;
  assign evt[`DCI_BIT_ADDR_ERR]   = addrErrSet;

  // ****************************************
  // Register decode
  // ****************************************
  // Full address compare: an aliased word would hide a wrong offset in software
  reg  selCtrl;
  reg  selStat;
  reg  selMask;
  wire wrCtrl;
  wire wrStat;
  wire wrMask;
  wire rdCtrl;
  wire rdStat;
  wire rdMask;

  always @* begin
    selCtrl = 1'b0;
    selStat = 1'b0;
    selMask = 1'b0;
    case (regAddr)
      `DCI_ADDR_IRQ_CTRL: begin
        selCtrl = 1'b1;
      end
      `DCI_ADDR_IRQ_STATUS: begin
        selStat = 1'b1;
      end
      `DCI_ADDR_IRQ_MASK: begin
        selMask = 1'b1;
      end
      default: begin
        selCtrl = 1'b0;
      end
    endcase
  end

  assign wrCtrl = regWrite && selCtrl;
  assign wrStat = regWrite && selStat;
  assign wrMask = regWrite && selMask;
  assign rdCtrl = regRead && selCtrl;
  assign rdStat = regRead && selStat;
  assign rdMask = regRead && selMask;

  // ****************************************
  // Enable byte
  // ****************************************
  reg [7:0] next_irqEn;

  // Bits outside 23 down to 16 of the write are dropped here
  always @* begin
    next_irqEn = irqEn;
    if (wrCtrl) begin
      next_irqEn = regWrData[`DCI_EN_MSB:`DCI_EN_LSB];
    end
  end

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      irqEn <= `DCI_EN_RESET;
    end else begin
      irqEn <= next_irqEn;
    end
  end

  // ****************************************
  // Mask byte
  // ****************************************
  reg [7:0] next_mask;

  always @* begin
    next_mask = mask;
    if (wrMask) begin
      next_mask = regWrData[`DCI_FLAG_MSB:`DCI_FLAG_LSB];
    end
  end

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      mask <= `DCI_MASK_RESET;
    end else begin
      mask <= next_mask;
    end
  end

  // ****************************************
  // Abort request
  // ****************************************
  reg next_abortReq;

  // Registered abortHit, high one cycle later for as long as the hit lasts; the transfer engine must stop on it
  always @* begin
    next_abortReq = abortHit;
  end

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      abortReq <= 1'b0;
    end else begin
      abortReq <= next_abortReq;
    end
  end

  // ****************************************
  // Flag and status bytes
  // ****************************************
  wire [7:0] next_flags;
  wire [7:0] next_status;
  wire [7:0] wrFlag;
  wire [7:0] clrStatus;

  // Set beats a software write in the same cycle, so no event is lost
  genvar i;
  generate
    for (i = 0; i < 8; i = i + 1) begin : gFlag
      assign wrFlag[i]      = regWrData[`DCI_FLAG_LSB + i];
      assign clrStatus[i]   = wrStat && regWrData[i];
      assign next_flags[i]  = evt[i] ? 1'b1 : (wrCtrl ? wrFlag[i] : flags[i]);
      assign next_status[i] = evt[i] ? 1'b1 : (clrStatus[i] ? 1'b0 : status[i]);
    end
  endgenerate

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      flags <= `DCI_FLAG_RESET;
    end else begin
      flags <= next_flags;
    end
  end

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      status <= `DCI_FLAG_RESET;
    end else begin
      status <= next_status;
    end
  end

  // ****************************************
  // Pending events
  // ****************************************
  wire [7:0] pendChan;
  wire [7:0] pendOut;

  generate
    for (i = 0; i < 8; i = i + 1) begin : gPend
      assign pendChan[i] = flags[i] && irqEn[i];
      assign pendOut[i]  = status[i] && mask[i];
    end
  endgenerate

  // ****************************************
  // Read path
  // ****************************************
  wire [31:0] ctrlWord;
  wire [31:0] statWord;
  wire [31:0] maskWord;
  reg  [31:0] next_rdData;

  assign ctrlWord[31:24] = 8'h00;
  assign ctrlWord[23]    = irqEn[7];
  assign ctrlWord[22]    = irqEn[6];
  assign ctrlWord[21]    = irqEn[5];
  assign ctrlWord[20]    = irqEn[4];
  assign ctrlWord[19]    = irqEn[3];
  assign ctrlWord[18]    = irqEn[2];
  assign ctrlWord[17]    = irqEn[1];
  assign ctrlWord[16]    = irqEn[0];
  assign ctrlWord[15:8]  = 8'h00;
  assign ctrlWord[7]     = flags[7];
  assign ctrlWord[6]     = flags[6];
  assign ctrlWord[5]     = flags[5];
  assign ctrlWord[4]     = flags[4];
  assign ctrlWord[3]     = flags[3];
  assign ctrlWord[2]     = flags[2];
  assign ctrlWord[1]     = flags[1];
  assign ctrlWord[0]     = flags[0];
  assign statWord[31:8]  = 24'h000000;
  assign statWord[7:0]   = status;
  assign maskWord[31:8]  = 24'h000000;
  assign maskWord[7:0]   = mask;

  // Unmapped offsets and idle cycles return zero
  always @* begin
    next_rdData = 32'h00000000;
    if (rdCtrl) begin
      next_rdData = ctrlWord;
    end
    if (rdStat) begin
      next_rdData = statWord;
    end
    if (rdMask) begin
      next_rdData = maskWord;
    end
  end

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      regRdData <= 32'h00000000;
    end else begin
      regRdData <= next_rdData;
    end
  end

  // ****************************************
  // Interrupt outputs
  // ****************************************
  // Combinational, so the request drops in the cycle after software clears it
  assign chanIrq = |pendChan;
  assign irqOut  = |pendOut;

endmodule // dci_channel_irq

`default_nettype wire

// ===== test/dci_channel_irq_chk.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// Checker
// ****
module dci_channel_irq_chk (
  // Clock and reset
  input wire logic        ref_clk,
  input wire logic        rst,
  // Register port
  input wire logic [3:0]  regAddr,
  input wire logic [31:0] regWrData,
  input wire logic        regWrite,
  input wire logic        regRead,
  input wire logic [31:0] regRdData,
  // Abort and interrupts
  input wire logic [7:0]  irqNumber,
  input wire logic        irqValid,
  input wire logic [7:0]  abortIrqSel,
  input wire logic        abortIrqEn,
  input wire logic        abortReq,
  input wire logic        chanIrq,
  input wire logic        irqOut
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  wire hit = irqValid && abortIrqEn && irqNumber == abortIrqSel;
  chk_rd_idle: assert property (!regRead |=> regRdData == 32'h0) else $error("rdata not zero");
  chk_rd_reserved: assert property (regRead && regAddr == 4'h0 |=> regRdData[31:24] == 8'h0 &&
    regRdData[15:8] == 8'h0) else $error("reserved bits set");
  chk_rd_unmapped: assert property (regRead && regAddr > 4'h8 |=> regRdData == 32'h0)
    else $error("unmapped read not zero");
  chk_enable_echo: assert property (regWrite && regAddr == 4'h0 ##1 regRead && regAddr == 4'h0
    |=> regRdData[23:16] == $past(regWrData[23:16], 2)) else $error("enable lost");
  chk_abort_pulse: assert property (hit |=> abortReq) else $error("abort missed");
  chk_abort_cause: assert property (abortReq |-> $past(hit)) else $error("stray abort");
  chk_irq_fall: assert property ($fell(chanIrq) |-> $past(regWrite))
    else $error("irq dropped alone");
  chk_out_fall: assert property ($fell(irqOut) |-> $past(regWrite)) else $error("irqOut dropped");
  cover property (abortReq);
  cover property ($rose(chanIrq));
  cover property ($rose(irqOut));
endmodule // dci_channel_irq_chk
`default_nettype wire

// ===== test/dci_channel_irq_tb.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// Bench
// ****
module dci_channel_irq_tb;
  logic        ref_clk = 0, rst = 1, regWrite = 0, regRead = 0, irqValid = 0;
  logic        srcHalfEvt = 0, dstDoneEvt = 0, dstHalfEvt = 0, blockDoneEvt = 0;
  logic        cellDoneEvt = 0, addrErrEvt = 0, abortIrqEn = 1, abortReq, chanIrq, irqOut;
  logic [3:0]  regAddr = 0;
  logic [31:0] regWrData = 0, regRdData;
  logic [15:0] source_position = 0, source_size = 16'h0005;
  logic [7:0]  irqNumber = 8'h29, abortIrqSel = 8'h2a;
  int          fail_count = 0, n_compared = 0;
  always #5 ref_clk = ~ref_clk;
  dci_channel_irq dut (.ref_clk, .rst, .regAddr, .regWrData, .regWrite, .regRead, .regRdData,
    .source_position, .source_size, .srcHalfEvt, .dstDoneEvt, .dstHalfEvt, .blockDoneEvt,
    .cellDoneEvt, .addrErrEvt, .irqNumber, .irqValid, .abortIrqSel, .abortIrqEn, .abortReq,
    .chanIrq, .irqOut);
  task chk(input string nm, input logic [31:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task wr(input [3:0] a, input [31:0] v);
    @(posedge ref_clk);
    {regAddr, regWrData, regWrite} <= {a, v, 1'b1};
    @(posedge ref_clk);
    regWrite <= 0;
    @(negedge ref_clk);
  endtask
  task rd(input [3:0] a, input [31:0] e);
    @(posedge ref_clk);
    {regAddr, regRead} <= {a, 1'b1};
    @(posedge ref_clk);
    regRead <= 0;
    @(negedge ref_clk);
    chk("rdata", regRdData, e);
  endtask
  // Events and irqValid pulse together for one cycle
  task ev(input [6:0] v);
    @(posedge ref_clk);
    {srcHalfEvt, dstDoneEvt, dstHalfEvt, blockDoneEvt, cellDoneEvt, addrErrEvt, irqValid} <= v;
    @(posedge ref_clk);
    {srcHalfEvt, dstDoneEvt, dstHalfEvt, blockDoneEvt, cellDoneEvt, addrErrEvt, irqValid} <= 0;
    @(negedge ref_clk);
  endtask
  task tally_and_finish;
    $display("compared %0d failed %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge ref_clk);
    rst <= 0;
    rd(4'h0, 32'h0);
    rd(4'h8, 32'h0);
    wr(4'h0, 32'hffffffff);
    rd(4'h0, 32'h00ff00ff);
    chk("irq", chanIrq, 1);
    rd(4'hc, 32'h0);
    // Each enable alone passes only its own flag
    for (int i = 0; i < 8; i++) begin
      wr(4'h0, 32'h10001 << i);
      chk("irq", chanIrq, 1);
      wr(4'h0, (32'h10000 << i) | (32'hff ^ (32'h1 << i)));
      chk("irq", chanIrq, 0);
    end
    wr(4'h0, 32'h0);
    for (int p = 1; p < 6; p++)
      @(posedge ref_clk) source_position <= 16'(p);
    rd(4'h0, 32'h80);
    wr(4'h0, 32'h0);
    ev(7'h7e);
    rd(4'h4, 32'hfd);
    rd(4'h0, 32'h7d);
    chk("irq", chanIrq, 0);
    chk("out", irqOut, 0);
    wr(4'h8, 32'h1);
    chk("out", irqOut, 1);
    wr(4'h4, 32'h1);
    chk("out", irqOut, 0);
    rd(4'h4, 32'hfc);
    wr(4'h0, 32'h20000);
    ev(7'h01);
    chk("abort", abortReq, 0);
    @(posedge ref_clk) irqNumber <= 8'h2a;
    ev(7'h01);
    chk("abort", abortReq, 1);
    chk("irq", chanIrq, 1);
    rd(4'h0, 32'h20002);
    // Write then read with no gap between the strobes
    @(posedge ref_clk) {regAddr, regWrData, regWrite} <= {4'h0, 32'h005a0000, 1'b1};
    @(posedge ref_clk) {regWrite, regRead} <= 2'b01;
    @(posedge ref_clk) regRead <= 0;
    @(negedge ref_clk) chk("rdata", regRdData, 32'h005a0000);
    tally_and_finish;
  end
endmodule // dci_channel_irq_tb
bind dci_channel_irq dci_channel_irq_chk chk (.ref_clk, .rst, .regAddr, .regWrData, .regWrite,
  .regRead, .regRdData, .irqNumber, .irqValid, .abortIrqSel, .abortIrqEn, .abortReq, .chanIrq,
  .irqOut);
`default_nettype wire
